/* File: port_io_cell_and_pin_assign.sv */
// Port I/O cells, priority crossbar and event capture with its registers.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps

// Contract
// - Port latch read shows pin state on digital pins
// - Select registers 0, 1 and 3 choose routed functions
// - Port 4 digital only, never crossbar routed
// - Reset: all cells hi-z, pull-up on
// - Analog pin: no pull-up, driver, receiver; an active debug link still drives and reads port 3 pin 0
// - Analog pin always reads zero
// - Input kind one makes pin digital
// - Drive mode one is push-pull
// - Drive mode zero is open-drain
// - Pull-up on when released, off driving low
// - Global disable turns off all pull-ups
// - Digital pin reads the pad level
// - Reserved pins skipped by crossbar, except fixed UART, CAN pins
// - First UART fixed on pins 4, 5
// - CAN fixed on port 0 pins 6, 7
// - Pin transition can interrupt or wake
// - Event capture works only on digital pins
// - External interrupts pick a port 1 pin
// - Oscillator pins are port 0 pins 2, 3
// - Port 3 pin 0 shared with debug
// - Crossbar takes least free pin in order
module port_io_cell_and_pin_assign (
  // Clock and reset.
  input wire logic mclk,
  input wire logic sys_rst,
  // Avalon-MM register slave.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pads, port 0 bit 0 up to port 4 bit 7.
  input wire logic [port_io_pkg::NUM_PADS-1:0] pad_in,
  output logic [port_io_pkg::NUM_PADS-1:0] pad_out,
  output logic [port_io_pkg::NUM_PADS-1:0] pad_oe,
  output logic [port_io_pkg::NUM_PADS-1:0] pad_pullup,
  output logic [port_io_pkg::NUM_MAIN-1:0] pad_analog,
  // Peripheral side.
  input wire logic uart_tx,
  output logic uart_rx,
  input wire logic can_tx,
  output logic can_rx,
  input wire logic [port_io_pkg::NUM_FUNC-1:0] func_out,
  output logic [port_io_pkg::NUM_FUNC-1:0] func_in,
  // Oscillator and debug sharing.
  input wire logic osc_enable,
  input wire logic debug_active,
  input wire logic debug_data_out,
  input wire logic debug_data_oe,
  output logic debug_data_signal,
  // Event capture.
  output logic ext_int0,
  output logic ext_int1,
  output logic port_match_event,
  output logic wake_event
);
  import port_io_pkg::*;

  typedef struct packed {
    bus_e bus;
    logic [31:0] rdata;
    logic [7:0] xbar_select_0;
    logic [7:0] xbar_select_1;
    logic [7:0] xbar_select_2;
    logic [7:0] xbar_select_3;
    logic [31:0] pin_input_kind_select;
    logic [31:0] pin_output_drive_select;
    logic [7:0] drive4;
    logic [31:0] pin_reserve_bit;
    logic [31:0] latch;
    logic [7:0] latch4;
    logic [7:0] ext_int_pin_config;
    logic [31:0] port_match_mask;
    logic [31:0] port_match_value;
    logic [39:0] sync1;
    logic [39:0] sync2;
    logic [39:0] pout;
    logic [39:0] poe;
    logic [39:0] ppu;
    logic [31:0] analog;
    logic [15:0] fin;
    logic uart_rx;
    logic can_rx;
    logic dbg_in;
    logic ext0;
    logic ext1;
    logic match;
    logic wake;
  } state_s;

  state_s st;
  state_s next_st;

  logic xen, pud, rel, val, drv, e0, e1, mt;
  logic [4:0] p0i, p1i;
  logic [5:0] lf;
  logic [15:0] fsel;
  logic [31:0] kind_eff, skip_eff, taken, rd, vals, rels;

  function automatic logic [31:0] merge_be(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    merge_be = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        merge_be[8*b +: 8] = wd[8*b +: 8];
      end
    end
  endfunction

  // Lowest pin not yet taken, with a valid flag on top.
  function automatic logic [5:0] lowest_free(input logic [31:0] tk);
    lowest_free = '0;
    for (int p = 31; p >= 0; p--) begin
      if (!tk[p]) begin
        lowest_free = {1'b1, 5'(p)};
      end
    end
  endfunction

  assign avs_waitrequest = (avs_read | avs_write) & (st.bus != BUS_ACK);

  always_comb begin
    next_st = st;
    next_st.sync1 = pad_in;
    next_st.sync2 = st.sync1;
    xen = st.xbar_select_2[XSEL2_ENABLE_BIT];
    pud = st.xbar_select_2[XSEL2_PUD_BIT];
    kind_eff = st.pin_input_kind_select;
    skip_eff = st.pin_reserve_bit;
    // The oscillator owns its two pins as analog while it runs.
    if (osc_enable) begin
      kind_eff[OSC_IN_PIN] = 1'b0;
      kind_eff[OSC_SECOND_PIN] = 1'b0;
      skip_eff[OSC_IN_PIN] = 1'b1;
      skip_eff[OSC_SECOND_PIN] = 1'b1;
    end
    rd = kind_eff & st.sync2[31:0];
    vals = st.latch;
    rels = '0;
    taken = skip_eff;
    // Fixed pins are claimed first, so the rest skips them.
    if (st.xbar_select_0[XSEL0_UART_BIT]) begin
      taken[UART_TX_PIN] = 1'b1;
      taken[UART_RX_PIN] = 1'b1;
      vals[UART_TX_PIN] = uart_tx;
      vals[UART_RX_PIN] = 1'b1;
      rels[UART_RX_PIN] = 1'b1;
    end
    if (st.xbar_select_0[XSEL0_CAN_BIT]) begin
      taken[CAN_TX_PIN] = 1'b1;
      taken[CAN_RX_PIN] = 1'b1;
      vals[CAN_TX_PIN] = can_tx;
      vals[CAN_RX_PIN] = 1'b1;
      rels[CAN_RX_PIN] = 1'b1;
    end
    fsel = {st.xbar_select_3, st.xbar_select_1};
    next_st.fin = '0;
    lf = '0;
    for (int f = 0; f < NUM_FUNC; f++) begin
      if (fsel[f]) begin
        lf = lowest_free(taken);
        if (lf[5]) begin
          taken[lf[4:0]] = 1'b1;
          vals[lf[4:0]] = func_out[f];
          next_st.fin[f] = rd[lf[4:0]];
        end
      end
    end
    next_st.uart_rx = rd[UART_RX_PIN];
    next_st.can_rx = rd[CAN_RX_PIN];
    rel = 1'b0;
    val = 1'b0;
    drv = 1'b0;
    // Pins of ports 0 to 3.
    for (int i = 0; i < NUM_MAIN; i++) begin
      rel = rels[i];
      val = vals[i];
      drv = st.pin_output_drive_select[i] & ~rel;
      next_st.analog[i] = ~kind_eff[i];
      if (!kind_eff[i]) begin
        next_st.poe[i] = 1'b0;
        next_st.pout[i] = 1'b0;
        next_st.ppu[i] = 1'b0;
      end else if (!xen) begin
        next_st.poe[i] = 1'b0;
        next_st.pout[i] = 1'b0;
        next_st.ppu[i] = ~pud;
      end else begin
        next_st.poe[i] = drv | ~val;
        next_st.pout[i] = drv & val;
        next_st.ppu[i] = ~pud & ~(drv | ~val);
      end
    end
    // Port 4 has no kind select, no reserve bit and no crossbar.
    for (int j = 0; j < NUM_P4; j++) begin
      drv = st.drive4[j];
      val = st.latch4[j];
      if (!xen) begin
        next_st.poe[32+j] = 1'b0;
        next_st.pout[32+j] = 1'b0;
        next_st.ppu[32+j] = ~pud;
      end else begin
        next_st.poe[32+j] = drv | ~val;
        next_st.pout[32+j] = drv & val;
        next_st.ppu[32+j] = ~pud & ~(drv | ~val);
      end
    end
    // The debug link takes the shared pin whenever it is active.
    if (debug_active) begin
      next_st.poe[DEBUG_PIN] = debug_data_oe;
      next_st.pout[DEBUG_PIN] = debug_data_out & debug_data_oe;
      next_st.ppu[DEBUG_PIN] = ~pud & ~debug_data_oe;
    end
    next_st.dbg_in = st.sync2[DEBUG_PIN];
    // Event capture reads the receiver, so analog pins never fire.
    p0i = {EXT_INT_PORT, st.ext_int_pin_config[2:0]};
    p1i = {EXT_INT_PORT, st.ext_int_pin_config[6:4]};
    e0 = kind_eff[p0i] & (st.sync2[p0i] == st.ext_int_pin_config[3]);
    e1 = kind_eff[p1i] & (st.sync2[p1i] == st.ext_int_pin_config[7]);
    mt = |((rd ^ st.port_match_value) & st.port_match_mask & kind_eff);
    next_st.ext0 = e0;
    next_st.ext1 = e1;
    next_st.match = mt;
    next_st.wake = (e0 & ~st.ext0) | (e1 & ~st.ext1) | (mt & ~st.match);
    // One wait state: data is fetched in the first cycle of a request.
    case (st.bus)
      BUS_IDLE: begin
        if (avs_read | avs_write) begin
          next_st.bus = BUS_ACK;
        end
        if (avs_read) begin
          case (avs_address)
            ADDR_XSEL0: next_st.rdata = {24'h0, st.xbar_select_0};
            ADDR_XSEL1: next_st.rdata = {24'h0, st.xbar_select_1};
            ADDR_XSEL2: next_st.rdata = {24'h0, st.xbar_select_2};
            ADDR_XSEL3: next_st.rdata = {24'h0, st.xbar_select_3};
            ADDR_KIND: next_st.rdata = st.pin_input_kind_select;
            ADDR_DRIVE: next_st.rdata = st.pin_output_drive_select;
            ADDR_DRIVE4: next_st.rdata = {24'h0, st.drive4};
            ADDR_SKIP: next_st.rdata = st.pin_reserve_bit;
            ADDR_LATCH: next_st.rdata = rd;
            ADDR_LATCH4: next_st.rdata = {24'h0, st.sync2[39:32]};
            ADDR_INTCFG: next_st.rdata = {24'h0, st.ext_int_pin_config};
            ADDR_MMASK: next_st.rdata = st.port_match_mask;
            ADDR_MVAL: next_st.rdata = st.port_match_value;
            ADDR_EVENT: next_st.rdata = {29'h0, st.match, st.ext1, st.ext0};
            default: next_st.rdata = '0;
          endcase
        end
      end
      BUS_ACK: begin
        next_st.bus = BUS_IDLE;
        if (avs_write) begin
          case (avs_address)
            ADDR_XSEL0: next_st.xbar_select_0 = 8'(merge_be({24'h0,
                st.xbar_select_0}, avs_writedata, avs_byteenable));
            ADDR_XSEL1: next_st.xbar_select_1 = 8'(merge_be({24'h0,
                st.xbar_select_1}, avs_writedata, avs_byteenable));
            ADDR_XSEL2: next_st.xbar_select_2 = 8'(merge_be({24'h0,
                st.xbar_select_2}, avs_writedata, avs_byteenable));
            ADDR_XSEL3: next_st.xbar_select_3 = 8'(merge_be({24'h0,
                st.xbar_select_3}, avs_writedata, avs_byteenable));
            ADDR_KIND: next_st.pin_input_kind_select = merge_be(
                st.pin_input_kind_select, avs_writedata, avs_byteenable);
            ADDR_DRIVE: next_st.pin_output_drive_select = merge_be(
                st.pin_output_drive_select, avs_writedata, avs_byteenable);
            ADDR_DRIVE4: next_st.drive4 = 8'(merge_be({24'h0, st.drive4},
                avs_writedata, avs_byteenable));
            ADDR_SKIP: next_st.pin_reserve_bit = merge_be(
                st.pin_reserve_bit, avs_writedata, avs_byteenable);
            ADDR_LATCH: next_st.latch = merge_be(st.latch, avs_writedata,
                avs_byteenable);
            ADDR_LATCH4: next_st.latch4 = 8'(merge_be({24'h0, st.latch4},
                avs_writedata, avs_byteenable));
            ADDR_INTCFG: next_st.ext_int_pin_config = 8'(merge_be({24'h0,
                st.ext_int_pin_config}, avs_writedata, avs_byteenable));
            ADDR_MMASK: next_st.port_match_mask = merge_be(
                st.port_match_mask, avs_writedata, avs_byteenable);
            ADDR_MVAL: next_st.port_match_value = merge_be(
                st.port_match_value, avs_writedata, avs_byteenable);
            default: next_st.bus = BUS_IDLE;
          endcase
        end
      end
      default: next_st.bus = BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.bus <= BUS_IDLE;
      st.pin_input_kind_select <= RST_KIND;
      st.latch <= RST_LATCH;
      st.latch4 <= RST_LATCH4;
      st.ppu <= '1;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.rdata;
  assign pad_out = st.pout;
  assign pad_oe = st.poe;
  assign pad_pullup = st.ppu;
  assign pad_analog = st.analog;
  assign uart_rx = st.uart_rx;
  assign can_rx = st.can_rx;
  assign func_in = st.fin;
  assign debug_data_signal = st.dbg_in;
  assign ext_int0 = st.ext0;
  assign ext_int1 = st.ext1;
  assign port_match_event = st.match;
  assign wake_event = st.wake;

  localparam logic [39:0] NODBG = ~(40'h1 << DEBUG_PIN);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_reset_hiz: assert property (
    !xen |=> ((pad_oe & NODBG) == '0))
    else $error("Cell drives a pad before the crossbar is enabled.");
  a_analog_off: assert property (
    ##1 (((pad_oe | pad_pullup) & NODBG & ~{8'hff, $past(kind_eff)}) == '0))
    else $error("Analog pin still has a driver or pull-up.");
  a_analog_read: assert property (
    (st.bus == BUS_IDLE && avs_read && avs_address == ADDR_LATCH)
    |=> ((avs_readdata & ~$past(kind_eff)) == '0))
    else $error("Analog pin did not read zero.");
  a_read_pad: assert property (
    (st.bus == BUS_IDLE && avs_read && avs_address == ADDR_LATCH)
    |=> (avs_readdata == ($past(kind_eff) & $past(st.sync2[31:0]))))
    else $error("Port read does not show the pad level.");
  a_open_drain: assert property (
    ##1 ((pad_out[31:0] & NODBG[31:0]
      & ~$past(st.pin_output_drive_select)) == '0))
    else $error("Open-drain pin drives high.");
  a_pullup_low: assert property (
    (pad_pullup & pad_oe & ~pad_out) == '0)
    else $error("Pull-up left on while the pad is driven low.");
  a_global_pud: assert property (
    pud |=> (pad_pullup == '0))
    else $error("Pull-up on while globally disabled.");
  a_uart_tx_pin: assert property (
    (xen && st.xbar_select_0[XSEL0_UART_BIT] && kind_eff[UART_TX_PIN]
      && st.pin_output_drive_select[UART_TX_PIN])
    |=> (pad_out[UART_TX_PIN] == $past(uart_tx) && pad_oe[UART_TX_PIN]))
    else $error("UART transmit not on its fixed pin.");
  a_match_flag: assert property (
    mt |=> port_match_event)
    else $error("Port mismatch did not raise the match event.");
  a_wake_rise: assert property (
    (mt && !port_match_event) |=> wake_event)
    else $error("New port mismatch did not raise a wake pulse.");
  c_xbar_on: cover property ($rose(xen));
  c_wake: cover property (wake_event);
  c_write: cover property (avs_write && !avs_waitrequest);

endmodule // port_io_cell_and_pin_assign

/* File: port_io_pkg.sv */
// Constants and encodings shared by the port I/O block.
package port_io_pkg;

  localparam int unsigned NUM_PADS = 40;
  localparam int unsigned NUM_MAIN = 32;
  localparam int unsigned NUM_P4 = 8;
  localparam int unsigned NUM_FUNC = 16;

  // Register byte offsets.
  localparam logic [7:0] ADDR_XSEL0 = 8'h00;
  localparam logic [7:0] ADDR_XSEL1 = 8'h04;
  localparam logic [7:0] ADDR_XSEL2 = 8'h08;
  localparam logic [7:0] ADDR_XSEL3 = 8'h0c;
  localparam logic [7:0] ADDR_KIND = 8'h10;
  localparam logic [7:0] ADDR_DRIVE = 8'h14;
  localparam logic [7:0] ADDR_DRIVE4 = 8'h18;
  localparam logic [7:0] ADDR_SKIP = 8'h1c;
  localparam logic [7:0] ADDR_LATCH = 8'h20;
  localparam logic [7:0] ADDR_LATCH4 = 8'h24;
  localparam logic [7:0] ADDR_INTCFG = 8'h28;
  localparam logic [7:0] ADDR_MMASK = 8'h2c;
  localparam logic [7:0] ADDR_MVAL = 8'h30;
  localparam logic [7:0] ADDR_EVENT = 8'h34;

  // Field positions.
  localparam int unsigned XSEL0_UART_BIT = 0;
  localparam int unsigned XSEL0_CAN_BIT = 1;
  localparam int unsigned XSEL2_ENABLE_BIT = 6;
  localparam int unsigned XSEL2_PUD_BIT = 7;
  localparam logic [4:0] UART_TX_PIN = 5'h04;
  localparam logic [4:0] UART_RX_PIN = 5'h05;
  localparam logic [4:0] CAN_TX_PIN = 5'h06;
  localparam logic [4:0] CAN_RX_PIN = 5'h07;
  localparam logic [4:0] OSC_IN_PIN = 5'h02;
  localparam logic [4:0] OSC_SECOND_PIN = 5'h03;
  localparam logic [4:0] DEBUG_PIN = 5'h18;
  localparam logic [1:0] EXT_INT_PORT = 2'h1;

  // Reset values.
  localparam logic [31:0] RST_KIND = 32'hffffffff;
  localparam logic [31:0] RST_LATCH = 32'hffffffff;
  localparam logic [7:0] RST_LATCH4 = 8'hff;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_e;

endpackage

/* File: port_io_pad_model.sv */
// Board-side model of the pads: external drivers, weak pull-ups, floating.
`timescale 1ns/1ps
module port_io_pad_model (
  // Clock.
  input wire logic mclk,
  // Device side of each pad.
  input wire logic [39:0] pad_out,
  input wire logic [39:0] pad_oe,
  input wire logic [39:0] pad_pullup,
  // External drivers on the board.
  input wire logic [39:0] ext_en,
  input wire logic [39:0] ext_lvl,
  // Level seen at each pad.
  output logic [39:0] pad_in
);
  logic [39:0] last;

  // A floating pad must not keep its old level, so it shows the inverse.
  always_ff @(posedge mclk) begin
    last <= pad_in;
  end

  always_comb begin
    for (int i = 0; i < 40; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_lvl[i];
      end else if (pad_pullup[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = (last[i] === 1'b0);
      end
    end
  end
endmodule // port_io_pad_model

/* File: port_io_cell_and_pin_assign_test.sv */
// Self-checking testbench of the port I/O block.
`timescale 1ns/1ps
module port_io_cell_and_pin_assign_test;
  import port_io_pkg::*;
  logic mclk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [39:0] pad_in, pad_out, pad_oe, pad_pullup, xen, xlv;
  logic [31:0] pad_analog;
  logic uart_tx, uart_rx, can_tx, can_rx, osc_enable, debug_active;
  logic debug_data_out, debug_data_oe, debug_data_signal;
  logic ext_int0, ext_int1, port_match_event, wake_event;
  logic [15:0] func_out, func_in;
  int n_mismatch, n_checks;

  port_io_cell_and_pin_assign u_port_io_cell_and_pin_assign (.mclk,
    .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pad_in, .pad_out,
    .pad_oe, .pad_pullup, .pad_analog, .uart_tx, .uart_rx, .can_tx,
    .can_rx, .func_out, .func_in, .osc_enable, .debug_active,
    .debug_data_out, .debug_data_oe, .debug_data_signal, .ext_int0,
    .ext_int1, .port_match_event, .wake_event);

  port_io_pad_model u_port_io_pad_model (.mclk(mclk), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_pullup(pad_pullup), .ext_en(xen),
    .ext_lvl(xlv), .pad_in(pad_in));

  task automatic chk(input logic [39:0] g, input logic [39:0] e,
      input string m);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  // The request stands until the rising edge at which waitrequest is seen
  // low; read data is taken at that edge, and only then is it dropped.
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk(40'(n), 40'h2, "bus wait states");
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(40'(q), 40'(e), "read data");
  endtask

  task automatic drv(input int i, input logic en, input logic lv);
    @(posedge mclk);
    xen[i] <= en;
    xlv[i] <= lv;
  endtask

  task automatic settle;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic t_reset;
    settle;
    chk(pad_oe, 40'h0, "oe after reset");
    chk(pad_pullup, {40{1'b1}}, "pull-up after reset");
    rchk(ADDR_KIND, RST_KIND);
    rchk(8'h3c, 32'h0);
    rchk(ADDR_LATCH, 32'hffffffff);
  endtask

  task automatic t_analog;
    drv(0, 1'b1, 1'b1);
    wr(ADDR_KIND, 32'hfffffffe);
    settle;
    chk(40'({pad_analog[0], pad_pullup[0], pad_oe[0]}), 40'h4, "mode");
    rchk(ADDR_LATCH, 32'hfffffffe);
    wr(ADDR_KIND, 32'hffffffff);
    rchk(ADDR_LATCH, 32'hffffffff);
    drv(0, 1'b0, 1'b0);
  endtask

  task automatic t_drive;
    wr(ADDR_SKIP, 32'hffffffff);
    wr(ADDR_XSEL2, 32'h40);
    wr(ADDR_DRIVE, 32'h100);
    wr(ADDR_LATCH, 32'hfffffcff);
    settle;
    chk(40'({pad_oe[9:8], pad_out[9:8]}), 40'hc, "drive low");
    chk(40'(pad_pullup[9:8]), 40'h0, "pull-up low");
    wr(ADDR_LATCH, 32'hffffffff);
    settle;
    chk(40'({pad_oe[9:8], pad_out[8]}), 40'h3, "drive high");
    chk(40'(pad_pullup[9]), 40'h1, "pull-up released");
    drv(9, 1'b1, 1'b0);
    settle;
    rchk(ADDR_LATCH, 32'hfffffdff);
    wr(ADDR_XSEL2, 32'hc0);
    settle;
    chk(pad_pullup, 40'h0, "global pull-up off");
    wr(ADDR_XSEL2, 32'h40);
    drv(9, 1'b0, 1'b0);
    wr(ADDR_DRIVE4, 32'h1);
    wr(ADDR_LATCH4, 32'hfe);
    settle;
    chk(40'({pad_oe[32], pad_out[32]}), 40'h2, "port 4 drive");
    wr(ADDR_LATCH4, 32'hff);
  endtask

  task automatic t_fixed;
    wr(ADDR_SKIP, 32'hffffff0f);
    wr(ADDR_DRIVE, 32'h150);
    drv(5, 1'b1, 1'b0);
    drv(7, 1'b1, 1'b1);
    can_tx <= 1'b1;
    wr(ADDR_XSEL0, 32'h3);
    settle;
    chk(40'({pad_oe[4], pad_out[4], uart_rx}), 40'h4, "uart 0");
    chk(40'({pad_oe[6], pad_out[6], can_rx}), 40'h7, "can");
    drv(5, 1'b1, 1'b1);
    uart_tx <= 1'b1;
    settle;
    chk(40'({pad_out[4], uart_rx}), 40'h3, "uart 1");
    wr(ADDR_XSEL0, 32'h0);
  endtask

  // Port 0 reserved: function 0 must land on pad 8 and function 1 on pad 9.
  task automatic t_xbar;
    wr(ADDR_SKIP, 32'h000000ff);
    drv(0, 1'b1, 1'b0);
    drv(8, 1'b1, 1'b1);
    drv(9, 1'b1, 1'b0);
    func_out <= 16'h0001;
    wr(ADDR_XSEL1, 32'h3);
    settle;
    chk(40'(func_in[1:0]), 40'h1, "function pins");
    wr(ADDR_XSEL1, 32'h0);
    wr(ADDR_SKIP, 32'hffffffff);
    xen <= 40'h0;
  endtask

  task automatic t_event;
    int n;
    n = 0;
    wr(ADDR_INTCFG, 32'h5b);
    drv(11, 1'b1, 1'b0);
    drv(13, 1'b1, 1'b1);
    settle;
    chk(40'({ext_int0, ext_int1}), 40'h0, "ints idle");
    drv(11, 1'b1, 1'b1);
    drv(13, 1'b1, 1'b0);
    while (wake_event !== 1'b1 && n < 10) begin
      @(negedge mclk);
      n++;
    end
    chk(40'(wake_event), 40'h1, "wake pulse");
    settle;
    chk(40'({ext_int0, ext_int1}), 40'h3, "ints active");
    wr(ADDR_KIND, 32'hfffff7ff);
    settle;
    chk(40'(ext_int0), 40'h0, "analog pin event");
    wr(ADDR_KIND, 32'hffffffff);
    wr(ADDR_MMASK, 32'h00010000);
    wr(ADDR_MVAL, 32'h00010000);
    drv(16, 1'b1, 1'b1);
    settle;
    chk(40'(port_match_event), 40'h0, "match equal");
    drv(16, 1'b1, 1'b0);
    settle;
    chk(40'(port_match_event), 40'h1, "match differs");
    rchk(ADDR_EVENT, 32'h7);
  endtask

  task automatic t_shared;
    @(posedge mclk);
    osc_enable <= 1'b1;
    debug_active <= 1'b1;
    debug_data_oe <= 1'b1;
    settle;
    chk(40'(pad_analog[3:2]), 40'h3, "osc pins");
    chk(40'({pad_oe[24], pad_out[24]}), 40'h2, "debug drive");
    drv(24, 1'b1, 1'b0);
    debug_data_oe <= 1'b0;
    settle;
    chk(40'(debug_data_signal), 40'h0, "debug in 0");
    drv(24, 1'b1, 1'b1);
    settle;
    chk(40'(debug_data_signal), 40'h1, "debug in 1");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    finish_test;
  end

  initial begin
    {sys_rst, avs_read, avs_write, uart_tx, can_tx} = 5'h10;
    {osc_enable, debug_active, debug_data_out, debug_data_oe} = 4'h0;
    {avs_address, avs_writedata, func_out} = '0;
    avs_byteenable = 4'hf;
    {xen, xlv} = '0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset;
    t_analog;
    t_drive;
    t_fixed;
    t_xbar;
    t_event;
    t_shared;
    finish_test;
  end
endmodule // port_io_cell_and_pin_assign_test
